// ---- src/pss_defines.svh ----
// Constants of the power state sequencer: timing, table layout, reset values
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Sequencing time base
`define PSS_CLK_HZ        100000000
`define PSS_OSC_HZ        32768
`define PSS_TICK_CYC      (`PSS_CLK_HZ / `PSS_OSC_HZ)

// Resource set and sequence storage
`define PSS_NUM_RES       8
`define PSS_ROM_LAST      4'hf
`define PSS_START_O2A     4'h0
`define PSS_START_A2O     4'h4
`define PSS_START_A2S     4'h8
`define PSS_START_S2A     4'ha
`define PSS_START_S2O     4'hc

// Resource defaults after supply arrival: only the clock regulator runs
`define PSS_RES_DEFAULT   16'h0001

`endif

// ---- src/pss_pkg.sv ----
// Types shared by the power state sequencer modules
package pss_pkg;

    typedef enum logic [2:0] {
        PSS_NO_SUPPLY = 3'h0,
        PSS_BACKUP    = 3'h1,
        PSS_OFF       = 3'h2,
        PSS_ACTIVE    = 3'h3,
        PSS_SLEEP     = 3'h4
    } pss_state_t;

    typedef enum logic [2:0] {
        PSS_OFF_TO_ACTIVE_SEQ   = 3'h0,
        PSS_ACTIVE_TO_OFF_SEQ   = 3'h1,
        PSS_ACTIVE_TO_SLEEP_SEQ = 3'h2,
        PSS_SLEEP_TO_ACTIVE_SEQ = 3'h3,
        PSS_SLEEP_TO_OFF_SEQ    = 3'h4
    } pss_seq_t;

    typedef enum logic [1:0] {
        PSS_PH_IDLE  = 2'h0,
        PSS_PH_CHECK = 2'h1,
        PSS_PH_RUN   = 2'h2
    } pss_phase_t;

    typedef enum logic [1:0] {
        PSS_MODE_OFF   = 2'h0,
        PSS_MODE_ON    = 2'h1,
        PSS_MODE_SLEEP = 2'h2
    } pss_mode_t;

    typedef enum logic [1:0] {
        PSS_POL_SKIP  = 2'h0,
        PSS_POL_CONT  = 2'h1,
        PSS_POL_IO    = 2'h2,
        PSS_POL_HALT  = 2'h3
    } pss_policy_t;

    // One stored register access
    typedef struct packed {
        logic       last;
        logic       io_up;
        logic [2:0] res;
        pss_mode_t  mode;
    } pss_entry_t;

    // Pins and comparator levels from outside the clock domain
    typedef struct packed {
        logic off_req;
        logic on_req;
        logic sleep_req;
        logic wake_req;
        logic above_por;
        logic above_sys_low;
        logic above_sys_high;
        logic hot;
        logic pwrdown;
        logic reset_in;
    } pss_pins_t;

    typedef pss_mode_t [7:0] pss_res_t;

endpackage

// ---- src/pss_otp_rom.sv ----
// Fixed sequence storage with comparison against the live fuse readback
`timescale 1ns/1ns
module pss_otp_rom (
    input  wire logic [3:0]         i_addr,
    input  wire pss_pkg::pss_entry_t i_otp_cur,
    output pss_pkg::pss_entry_t      o_entry,
    output logic                     o_mismatch
);

    // Preprogrammed image; constant, so no run-time path can change it
    localparam logic [6:0] ROM [16] = '{
        7'h05, 7'h29, 7'h0d, 7'h51,
        7'h10, 7'h0c, 7'h08, 7'h44,
        7'h0e, 7'h50, 7'h11, 7'h4d,
        7'h10, 7'h0c, 7'h08, 7'h44
    };

    // Lookup and integrity compare
    always_comb begin
        o_entry    = pss_pkg::pss_entry_t'(ROM[i_addr]);
        o_mismatch = (i_otp_cur != o_entry);
    end

endmodule

// ---- src/pss_controller.sv ----
// Embedded power controller: arbitration, power state machine, sequencer
`timescale 1ns/1ns
`include "pss_defines.svh"
module pss_controller (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire pss_pkg::pss_pins_t    i_pins,
    input  wire logic                  i_irq_pending,
    input  wire logic                  i_wake_to_off,
    input  wire logic                  i_crc_en,
    input  wire pss_pkg::pss_policy_t  i_crc_policy,
    input  wire pss_pkg::pss_entry_t   i_otp_cur,
    input  wire logic                  i_irq_clr,
    input  wire logic                  i_host_wr,
    input  wire logic [2:0]            i_host_res,
    input  wire pss_pkg::pss_mode_t    i_host_mode,
    output pss_pkg::pss_state_t        o_state,
    output pss_pkg::pss_seq_t          o_seq,
    output logic                       o_busy,
    output logic                       o_halted,
    output logic [3:0]                 o_otp_addr,
    output pss_pkg::pss_res_t          o_res_mode,
    output logic [7:0]                 o_res_keep,
    output logic                       o_prog_memory_error_irq
);

    pss_pkg::pss_pins_t   pins_m;
    pss_pkg::pss_pins_t   pins;
    logic [11:0]          tick_cnt;
    logic [11:0]          next_tick_cnt;
    logic                 tick;
    pss_pkg::pss_state_t  st;
    pss_pkg::pss_state_t  next_st;
    pss_pkg::pss_seq_t    seq;
    pss_pkg::pss_seq_t    next_seq;
    pss_pkg::pss_phase_t  ph;
    pss_pkg::pss_phase_t  next_ph;
    logic [3:0]           ptr;
    logic [3:0]           next_ptr;
    logic                 err;
    logic                 next_err;
    logic                 halted;
    logic                 next_halted;
    logic                 irq;
    logic                 next_irq;
    pss_pkg::pss_res_t    res;
    pss_pkg::pss_res_t    next_res;
    pss_pkg::pss_entry_t  entry;
    logic                 mismatch;
    logic                 on_ok;
    logic                 err_set;

    // Comparator levels and pins cross two flops before any use
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pins_m <= '0;
            pins   <= '0;
        end else begin
            pins_m <= i_pins;
            pins   <= pins_m;
        end
    end

    // Divider standing in for the slow oscillator edge
    always_comb begin
        tick          = (tick_cnt == 12'(`PSS_TICK_CYC - 1));
        next_tick_cnt = tick ? 12'h000 : tick_cnt + 12'h001;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt <= 12'h000;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // Storage is read only; the same port feeds execution and the check
    pss_otp_rom u_rom (
        .i_addr     (ptr),
        .i_otp_cur  (i_otp_cur),
        .o_entry    (entry),
        .o_mismatch (mismatch)
    );

    function automatic logic [3:0] seq_start(input pss_pkg::pss_seq_t s);
        case (s)
            pss_pkg::PSS_OFF_TO_ACTIVE_SEQ:   seq_start = `PSS_START_O2A;
            pss_pkg::PSS_ACTIVE_TO_OFF_SEQ:   seq_start = `PSS_START_A2O;
            pss_pkg::PSS_ACTIVE_TO_SLEEP_SEQ: seq_start = `PSS_START_A2S;
            pss_pkg::PSS_SLEEP_TO_ACTIVE_SEQ: seq_start = `PSS_START_S2A;
            default:                          seq_start = `PSS_START_S2O;
        endcase
    endfunction

    function automatic pss_pkg::pss_state_t seq_target(input pss_pkg::pss_seq_t s);
        case (s)
            pss_pkg::PSS_OFF_TO_ACTIVE_SEQ,
            pss_pkg::PSS_SLEEP_TO_ACTIVE_SEQ: seq_target = pss_pkg::PSS_ACTIVE;
            pss_pkg::PSS_ACTIVE_TO_SLEEP_SEQ: seq_target = pss_pkg::PSS_SLEEP;
            default:                          seq_target = pss_pkg::PSS_OFF;
        endcase
    endfunction

    // Arbitration, state machine and sequencer share one next-state block
    always_comb begin
        next_st     = st;
        next_seq    = seq;
        next_ph     = ph;
        next_ptr    = ptr;
        next_err    = err;
        next_halted = halted;
        next_res    = res;
        err_set     = 1'b0;
        on_ok       = pins.on_req && pins.above_sys_high && !pins.hot
                      && !pins.pwrdown && !pins.reset_in;
        if (i_host_wr) begin
            next_res[i_host_res] = i_host_mode;
        end
        if (!pins.above_por) begin
            next_st = pss_pkg::PSS_NO_SUPPLY;
            next_ph = pss_pkg::PSS_PH_IDLE;
        end else if (!pins.above_sys_low) begin
            next_st = pss_pkg::PSS_BACKUP;
            next_ph = pss_pkg::PSS_PH_IDLE;
        end else if (st == pss_pkg::PSS_NO_SUPPLY || st == pss_pkg::PSS_BACKUP) begin
            // Hardware bring-up to off, no sequence involved
            next_st  = pss_pkg::PSS_OFF;
            next_res = pss_pkg::pss_res_t'(`PSS_RES_DEFAULT);
        end else if (pins.off_req && st != pss_pkg::PSS_OFF
                     && !(ph != pss_pkg::PSS_PH_IDLE
                          && (seq == pss_pkg::PSS_ACTIVE_TO_OFF_SEQ
                              || seq == pss_pkg::PSS_SLEEP_TO_OFF_SEQ))) begin
            // Off preempts other requests and any running sequence except an off sequence
            next_seq    = (st == pss_pkg::PSS_SLEEP) ? pss_pkg::PSS_SLEEP_TO_OFF_SEQ
                                                     : pss_pkg::PSS_ACTIVE_TO_OFF_SEQ;
            next_ph     = pss_pkg::PSS_PH_RUN;
            next_ptr    = seq_start(next_seq);
            next_halted = 1'b0;
        end else if (pins.off_req && st == pss_pkg::PSS_OFF) begin
            next_ph = pss_pkg::PSS_PH_IDLE;
        end else if (ph == pss_pkg::PSS_PH_IDLE) begin
            // On, sleep and wake requests are only looked at between sequences
            if (st == pss_pkg::PSS_OFF && on_ok) begin
                next_seq    = pss_pkg::PSS_OFF_TO_ACTIVE_SEQ;
                next_halted = 1'b0;
                next_err    = 1'b0;
                if (i_crc_en && i_crc_policy != pss_pkg::PSS_POL_SKIP) begin
                    next_ph  = pss_pkg::PSS_PH_CHECK;
                    next_ptr = 4'h0;
                end else begin
                    next_ph  = pss_pkg::PSS_PH_RUN;
                    next_ptr = `PSS_START_O2A;
                end
            end else if (st == pss_pkg::PSS_ACTIVE && pins.sleep_req && !i_irq_pending) begin
                next_seq = pss_pkg::PSS_ACTIVE_TO_SLEEP_SEQ;
                next_ph  = pss_pkg::PSS_PH_RUN;
                next_ptr = `PSS_START_A2S;
            end else if (st == pss_pkg::PSS_SLEEP && pins.wake_req) begin
                next_seq = i_wake_to_off ? pss_pkg::PSS_SLEEP_TO_OFF_SEQ
                                         : pss_pkg::PSS_SLEEP_TO_ACTIVE_SEQ;
                next_ph  = pss_pkg::PSS_PH_RUN;
                next_ptr = seq_start(next_seq);
            end
        end else if (ph == pss_pkg::PSS_PH_CHECK) begin
            // Walk every stored word, one per clock
            err_set  = mismatch;
            next_err = err || mismatch;
            next_ptr = ptr + 4'h1;
            if (ptr == `PSS_ROM_LAST) begin
                if (next_err && i_crc_policy == pss_pkg::PSS_POL_HALT) begin
                    next_ph     = pss_pkg::PSS_PH_IDLE;
                    next_halted = 1'b1;
                end else begin
                    next_ph  = pss_pkg::PSS_PH_RUN;
                    next_ptr = `PSS_START_O2A;
                end
            end
        end else if (tick) begin
            // One register access per oscillator period
            next_res[entry.res] = entry.mode;
            next_ptr = ptr + 4'h1;
            if (entry.last) begin
                next_ph = pss_pkg::PSS_PH_IDLE;
                next_st = seq_target(seq);
            end else if (entry.io_up && err && seq == pss_pkg::PSS_OFF_TO_ACTIVE_SEQ
                         && i_crc_policy == pss_pkg::PSS_POL_IO) begin
                // Rail up, rest withheld; state stays off
                next_ph     = pss_pkg::PSS_PH_IDLE;
                next_halted = 1'b1;
            end
        end
        // Set beats a simultaneous clear
        next_irq = (irq && !i_irq_clr) || err_set;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st     <= pss_pkg::PSS_NO_SUPPLY;
            seq    <= pss_pkg::PSS_OFF_TO_ACTIVE_SEQ;
            ph     <= pss_pkg::PSS_PH_IDLE;
            ptr    <= 4'h0;
            err    <= 1'b0;
            halted <= 1'b0;
            irq    <= 1'b0;
            res    <= pss_pkg::pss_res_t'(`PSS_RES_DEFAULT);
        end else begin
            st     <= next_st;
            seq    <= next_seq;
            ph     <= next_ph;
            ptr    <= next_ptr;
            err    <= next_err;
            halted <= next_halted;
            irq    <= next_irq;
            res    <= next_res;
        end
    end

    // A resource left on keeps its linked subsystems alive
    for (genvar g = 0; g < `PSS_NUM_RES; g++) begin : g_keep
        assign o_res_keep[g] = (res[g] == pss_pkg::PSS_MODE_ON);
    end

    assign o_state                 = st;
    assign o_seq                   = seq;
    assign o_busy                  = (ph != pss_pkg::PSS_PH_IDLE);
    assign o_halted                = halted;
    assign o_otp_addr              = ptr;
    assign o_res_mode              = res;
    assign o_prog_memory_error_irq = irq;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    logic starting;
    assign starting = (ph == pss_pkg::PSS_PH_IDLE) && (next_ph != pss_pkg::PSS_PH_IDLE);

    chk_no_supply: assert property (
        !pins.above_por |=> st == pss_pkg::PSS_NO_SUPPLY && !o_busy)
        else $error("no-supply state not taken below power-on level");

    chk_backup_state: assert property (
        pins.above_por && !pins.above_sys_low |=> st == pss_pkg::PSS_BACKUP)
        else $error("backup state not taken below system low");

    chk_on_gated: assert property (
        starting && next_seq == pss_pkg::PSS_OFF_TO_ACTIVE_SEQ
        |-> pins.on_req && pins.above_sys_high && !pins.hot && !pins.pwrdown
            && !pins.reset_in && st == pss_pkg::PSS_OFF)
        else $error("power-up started while gated");

    chk_sleep_gated: assert property (
        starting && next_seq == pss_pkg::PSS_ACTIVE_TO_SLEEP_SEQ |-> !i_irq_pending)
        else $error("sleep started with pending interrupt");

    chk_wake_in_sleep: assert property (
        starting && next_seq == pss_pkg::PSS_SLEEP_TO_ACTIVE_SEQ |-> st == pss_pkg::PSS_SLEEP)
        else $error("wake sequence outside sleep");

    chk_off_wins: assert property (
        st == pss_pkg::PSS_ACTIVE && !o_busy && pins.off_req && pins.above_sys_low
        && pins.on_req && pins.sleep_req
        |=> o_busy && seq == pss_pkg::PSS_ACTIVE_TO_OFF_SEQ)
        else $error("off request lost against other requests");

    chk_err_flags: assert property (
        ph == pss_pkg::PSS_PH_CHECK && mismatch && pins.above_sys_low
        |=> o_prog_memory_error_irq [*2])
        else $error("memory error flag not raised");

    chk_step_tick: assert property (
        ph == pss_pkg::PSS_PH_RUN && !tick && !pins.off_req && $stable(ph)
        ##1 ph == pss_pkg::PSS_PH_RUN
        |-> ptr == $past(ptr))
        else $error("sequence stepped without an oscillator tick");

    chk_legal_move: assert property (
        $changed(st) && st == pss_pkg::PSS_ACTIVE
        |-> $past(st) == pss_pkg::PSS_OFF || $past(st) == pss_pkg::PSS_SLEEP)
        else $error("illegal entry into active state");

    chk_halt_policy: assert property (
        ph == pss_pkg::PSS_PH_CHECK && ptr == `PSS_ROM_LAST && (err || mismatch)
        && i_crc_policy == pss_pkg::PSS_POL_HALT && pins.above_sys_low && !pins.off_req
        |=> o_halted && !o_busy ##1 st == pss_pkg::PSS_OFF)
        else $error("power-up not halted on integrity error");

    cov_active: cover property (st == pss_pkg::PSS_OFF ##1 st == pss_pkg::PSS_ACTIVE);
    cov_sleep: cover property (st == pss_pkg::PSS_ACTIVE ##1 st == pss_pkg::PSS_SLEEP);
    cov_err: cover property ($rose(o_prog_memory_error_irq));
    cov_halt: cover property ($rose(o_halted));

endmodule

// ---- dv/pss_otp_model.sv ----
// Fuse readback model for the sequence storage, with a fault injector
`timescale 1ns/1ns
module pss_otp_model (
    input  wire logic [3:0]           i_addr,
    input  wire logic                 i_flip,
    output pss_pkg::pss_entry_t       o_cur
);
    // Stored image never changes while running; only i_flip disturbs it
    localparam logic [6:0] IMG [16] = '{7'h05, 7'h29, 7'h0d, 7'h51, 7'h10, 7'h0c, 7'h08,
                                        7'h44, 7'h0e, 7'h50, 7'h11, 7'h4d, 7'h10, 7'h0c,
                                        7'h08, 7'h44};

    // Fault sits in a power-down word so a completed power-up stays clean
    assign o_cur = pss_pkg::pss_entry_t'(IMG[i_addr] ^ {6'h00, i_flip & (i_addr == 4'h7)});
endmodule

// ---- dv/tb_pss_controller.sv ----
// Self-checking bench for the power state sequencer controller
`timescale 1ns/1ns
module tb_pss_controller;
    localparam int LIMIT = 95000;
    localparam logic [6:0] IMG [16] = '{7'h05, 7'h29, 7'h0d, 7'h51, 7'h10, 7'h0c, 7'h08,
                                        7'h44, 7'h0e, 7'h50, 7'h11, 7'h4d, 7'h10, 7'h0c,
                                        7'h08, 7'h44};
    logic                 i_clk     = 1'b0;
    logic                 i_rst_b   = 1'b0;
    pss_pkg::pss_pins_t   pins      = '0;
    logic                 irq_pend  = 1'b0;
    logic                 wake_off  = 1'b0;
    logic                 crc_en    = 1'b1;
    logic                 irq_clr   = 1'b0;
    logic                 host_wr   = 1'b0;
    logic                 flip      = 1'b0;
    logic [2:0]           host_res  = 3'h0;
    pss_pkg::pss_mode_t   host_mode = pss_pkg::PSS_MODE_OFF;
    pss_pkg::pss_policy_t policy    = pss_pkg::PSS_POL_CONT;
    pss_pkg::pss_entry_t  otp_cur;
    pss_pkg::pss_state_t  state;
    pss_pkg::pss_seq_t    seq;
    pss_pkg::pss_res_t    res_mode;
    logic                 busy;
    logic                 halted;
    logic                 mem_irq;
    logic [3:0]           otp_addr;
    logic [7:0]           res_keep;
    logic [15:0]          exp_res   = 16'h0001;
    logic [2:0]           hr;
    int                   err_total = 0;
    int                   tests_run = 0;
    int                   cyc       = 0;

    always #5 i_clk = ~i_clk;

    pss_controller i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pins(pins),
        .i_irq_pending(irq_pend), .i_wake_to_off(wake_off), .i_crc_en(crc_en),
        .i_crc_policy(policy), .i_otp_cur(otp_cur), .i_irq_clr(irq_clr),
        .i_host_wr(host_wr), .i_host_res(host_res), .i_host_mode(host_mode),
        .o_state(state), .o_seq(seq), .o_busy(busy), .o_halted(halted),
        .o_otp_addr(otp_addr), .o_res_mode(res_mode), .o_res_keep(res_keep),
        .o_prog_memory_error_irq(mem_irq));

    pss_otp_model i_otp (.i_addr(otp_addr), .i_flip(flip), .o_cur(otp_cur));

    // Replays stored words onto an expected resource image
    function automatic logic [15:0] apply(input logic [15:0] r, input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            r[2 * int'(IMG[i][4:2]) +: 2] = IMG[i][1:0];
        end
        return r;
    endfunction

    function automatic logic [7:0] keep_of(input logic [15:0] r);
        logic [7:0] k;
        for (int i = 0; i < 8; i++) begin
            k[i] = (r[2 * i +: 2] == 2'h1);
        end
        return k;
    endfunction

    task automatic note(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask

    task automatic chk_state(input pss_pkg::pss_state_t e);
        note(state === e, "state");
    endtask

    task automatic chk_seq(input pss_pkg::pss_seq_t e);
        note(seq === e, "sequence");
    endtask

    task automatic chk_res();
        note(res_mode === exp_res && res_keep === keep_of(exp_res), "resources");
    endtask

    task automatic chk_flag(input logic g, input logic e, input string w);
        note(g === e, w);
    endtask

    // Sample a settled cycle after the edge, never in its own time step
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic req(input int w, input logic v);
        @(posedge i_clk);
        case (w)
            0: pins.off_req <= v;
            1: pins.on_req <= v;
            2: pins.sleep_req <= v;
            3: pins.wake_req <= v;
            4: pins.above_por <= v;
            5: pins.above_sys_low <= v;
            6: pins.above_sys_high <= v;
            7: pins.hot <= v;
            8: pins.pwrdown <= v;
            9: pins.reset_in <= v;
            default: begin
                pins.off_req <= v;
                pins.on_req <= v;
                pins.sleep_req <= v;
            end
        endcase
    endtask

    task automatic wait_busy(input logic v, input int lim);
        int n;
        n = 0;
        while (busy !== v && n < lim) begin
            step(1);
            n++;
        end
        chk_flag(busy, v, "busy");
    endtask

    // Request must be ignored: no sequence has started eight clocks after it, well past the sync delay
    task automatic refused(input int w);
        req(w, 1'b1);
        step(8);
        chk_flag(busy, 1'b0, "busy");
        req(w, 1'b0);
    endtask

    // Requests are levels, so hold until the sequencer takes them
    task automatic go(input int w, input pss_pkg::pss_seq_t sq,
                      input pss_pkg::pss_state_t st, input int lo, input int hi);
        req(w, 1'b1);
        wait_busy(1'b1, 20);
        req(w, 1'b0);
        chk_seq(sq);
        wait_busy(1'b0, 20000);
        chk_state(st);
        exp_res = apply(exp_res, lo, hi);
        chk_res();
    endtask

    task automatic clear_irq();
        @(posedge i_clk);
        irq_clr <= 1'b1;
        @(posedge i_clk);
        irq_clr <= 1'b0;
        step(2);
        chk_flag(mem_irq, 1'b0, "irq clear");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard sized for eight tick-paced sequences
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            $display("MISMATCH t=%0t timeout", $time);
            conclude();
        end
    end

    initial begin
        void'($urandom(47));
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        step(5);
        chk_state(pss_pkg::PSS_NO_SUPPLY);
        chk_res();
        $display("test reset done");
        req(4, 1'b1);
        step(6);
        chk_state(pss_pkg::PSS_BACKUP);
        refused(1);
        req(5, 1'b1);
        step(6);
        chk_state(pss_pkg::PSS_OFF);
        chk_res();
        refused(1);
        req(6, 1'b1);
        req(7, 1'b1);
        refused(1);
        req(7, 1'b0);
        req(8, 1'b1);
        refused(1);
        req(8, 1'b0);
        req(9, 1'b1);
        refused(1);
        req(9, 1'b0);
        $display("test supply done");
        go(1, pss_pkg::PSS_OFF_TO_ACTIVE_SEQ, pss_pkg::PSS_ACTIVE, 0, 3);
        chk_flag(mem_irq, 1'b0, "irq");
        // Random host writes to resources that no sequence touches
        for (int k = 0; k < 6; k++) begin
            hr = 3'h5 + 3'($urandom % 3);
            @(posedge i_clk);
            host_wr <= 1'b1;
            host_res <= hr;
            host_mode <= pss_pkg::pss_mode_t'($urandom % 3);
            @(posedge i_clk);
            host_wr <= 1'b0;
            step(1);
            exp_res[2 * int'(hr) +: 2] = host_mode;
            chk_res();
        end
        refused(3);
        @(posedge i_clk);
        irq_pend <= 1'b1;
        refused(2);
        // Hold the pending interrupt until the synced sleep level has dropped
        repeat (3) @(posedge i_clk);
        irq_pend <= 1'b0;
        go(2, pss_pkg::PSS_ACTIVE_TO_SLEEP_SEQ, pss_pkg::PSS_SLEEP, 8, 9);
        go(3, pss_pkg::PSS_SLEEP_TO_ACTIVE_SEQ, pss_pkg::PSS_ACTIVE, 10, 11);
        go(10, pss_pkg::PSS_ACTIVE_TO_OFF_SEQ, pss_pkg::PSS_OFF, 4, 7);
        $display("test cycle done");
        flip <= 1'b1;
        // Halt, stop at io rail, then continue, each with a bad stored word
        for (int p = 3; p > 0; p--) begin
            @(posedge i_clk);
            policy <= pss_pkg::pss_policy_t'(p);
            go(1, pss_pkg::PSS_OFF_TO_ACTIVE_SEQ,
               (p == 1) ? pss_pkg::PSS_ACTIVE : pss_pkg::PSS_OFF,
               (p == 3) ? 1 : 0, (p == 1) ? 3 : ((p == 2) ? 1 : 0));
            chk_flag(mem_irq, 1'b1, "irq set");
            if (p > 1) begin
                chk_flag(halted, 1'b1, "halted");
            end else begin
                chk_flag(halted, 1'b0, "halted");
            end
            clear_irq();
        end
        flip <= 1'b0;
        $display("test integrity done");
        go(2, pss_pkg::PSS_ACTIVE_TO_SLEEP_SEQ, pss_pkg::PSS_SLEEP, 8, 9);
        wake_off <= 1'b1;
        go(3, pss_pkg::PSS_SLEEP_TO_OFF_SEQ, pss_pkg::PSS_OFF, 12, 15);
        $display("test wake off done");
        conclude();
    end
endmodule
